// ---- rtl/aocr_byte_reg.sv ----
// One byte-wide configuration register with write strobe and reset value
`timescale 1ns/100ps
module aocr_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_VALUE;
    end else if (wr_en) begin
      q <= wr_data & WRITE_MASK;
    end
  end
endmodule

// ---- rtl/aocr_pkg.sv ----
// Register map, field layout and configuration carriers of the output path config bank
package aocr_pkg;
  localparam int ADDR_W = 12;
  // Register offsets are not all word multiples, so each is an index; byte address is four times it
  localparam logic [7:0] IDX_AVG = 8'h15;
  localparam logic [7:0] IDX_OFS_L = 8'h16;
  localparam logic [7:0] IDX_OFS_M = 8'h17;
  localparam logic [7:0] IDX_OFS_H = 8'h18;
  localparam logic [7:0] IDX_GAIN_L = 8'h1C;
  localparam logic [7:0] IDX_GAIN_H = 8'h1D;
  localparam logic [7:0] IDX_FMT = 8'h20;
  localparam logic [7:0] IDX_OSC = 8'h21;
  localparam logic [7:0] IDX_DRV = 8'h22;
  localparam logic [7:0] IDX_TW0 = 8'h23;
  localparam logic [7:0] IDX_TW3 = 8'h26;
  localparam int NUM_TW = 4;

  localparam logic [7:0] RST_AVG = 8'h00;
  localparam logic [7:0] RST_OFS = 8'h00;
  localparam logic [7:0] RST_GAIN_L = 8'h00;
  localparam logic [7:0] RST_GAIN_H = 8'h80;
  localparam logic [7:0] RST_FMT = 8'h00;
  localparam logic [7:0] RST_OSC = 8'h00;
  localparam logic [7:0] RST_DRV = 8'h00;
  localparam logic [7:0] RST_TW0 = 8'h0F;
  localparam logic [7:0] RST_TW1 = 8'h0F;
  localparam logic [7:0] RST_TW2 = 8'h5A;
  localparam logic [7:0] RST_TW3 = 8'h5A;

  localparam int AVG_RESTART_BIT = 7;
  localparam logic [4:0] BLK_LEN_MAX = 5'h10;
  localparam logic [15:0] GAIN_UNITY = 16'h8000;
  localparam int GAIN_SHIFT = 15;

  // Result word lengths per output format
  localparam logic [5:0] WORD_24 = 6'h18;
  localparam logic [5:0] WORD_32 = 6'h20;

  typedef enum logic [1:0] {LANES_1, LANES_2, LANES_4, LANES_BAD} aocr_lane_type;
  typedef enum logic [1:0] {CLK_HOST, CLK_ECHO, CLK_DEVICE, CLK_BAD} aocr_clk_type;
  typedef enum logic [2:0] {
    FMT_D24, FMT_D16_CM8, FMT_D24_CM8, FMT_AVG30, FMT_TEST, FMT_R5, FMT_R6, FMT_R7
  } aocr_fmt_type;

  typedef struct packed {
    logic [4:0] block_length_exponent;
    logic [16:0] block_samples;
    logic averaging_on;
    logic averaging_restart;
    logic signed [23:0] offset_word;
    logic [15:0] gain_word;
    aocr_lane_type output_lane_select;
    aocr_clk_type clocking_scheme_select;
    logic double_rate_select;
    aocr_fmt_type output_word_format;
    logic [5:0] word_bits;
    logic [5:0] pulse_count_limit;
    logic [1:0] oscillator_divider;
    logic strong_drive_select;
    logic [31:0] fixed_test_word;
  } aocr_cfg_type;

  typedef struct packed {
    logic signed [23:0] diff;
    logic [7:0] common_mode;
    logic signed [29:0] avg_diff;
    logic overrange;
    logic block_sync;
  } aocr_result_type;
endpackage

// ---- rtl/aocr_regs.sv ----
// APB configuration bank for the converter output path, with correction and framing
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module aocr_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [aocr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic signed [23:0] sample_diff,
  input wire logic [7:0] sample_cm,
  output aocr_pkg::aocr_cfg_type cfg,
  output aocr_pkg::aocr_result_type result,
  output logic [31:0] frame_word,
  output logic frame_valid,
  output logic [2:0] oscillator_divider_factor
);
  import aocr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  localparam int NREG = 13;
  localparam logic [7:0] IDX_TAB [NREG] = '{
    IDX_AVG, IDX_OFS_L, IDX_OFS_M, IDX_OFS_H, IDX_GAIN_L, IDX_GAIN_H,
    IDX_FMT, IDX_OSC, IDX_DRV, IDX_TW0, 8'h24, 8'h25, IDX_TW3
  };
  localparam logic [7:0] RST_TAB [NREG] = '{
    RST_AVG, RST_OFS, RST_OFS, RST_OFS, RST_GAIN_L, RST_GAIN_H,
    RST_FMT, RST_OSC, RST_DRV, RST_TW0, RST_TW1, RST_TW2, RST_TW3
  };
  // Read-only and reserved bits are masked off at write time
  localparam logic [7:0] MSK_TAB [NREG] = '{
    8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h03, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF
  };

  logic access;
  logic word_ok;
  logic [7:0] idx;
  logic [NREG-1:0] hit;
  logic [7:0] q [NREG];
  logic mapped;
  logic restart_wr;

  assign access = psel && penable;
  assign word_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
  assign idx = paddr[9:2];
  assign mapped = |hit;
  assign restart_wr = access && pwrite && hit[0] && pstrb[0] && pwdata[AVG_RESTART_BIT];
  assign pready = 1'b1;
  // Unmapped or misaligned addresses answer with an error and change nothing
  assign pslverr = access && !mapped;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign hit[g] = word_ok && (idx == IDX_TAB[g]);
      aocr_byte_reg #(
        .RESET_VALUE(RST_TAB[g]),
        .WRITE_MASK(MSK_TAB[g])
      ) u_reg (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(access && pwrite && hit[g] && pstrb[0]),
        .wr_data(pwdata[7:0]),
        .q(q[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // State: one struct, one comb, one flop

  typedef struct packed {
    logic restart;
    logic [16:0] count;
    logic signed [46:0] acc;
    logic ovr;
    logic sync_pend;
    logic [31:0] frame;
    logic fvalid;
    logic [31:0] rdata;
    aocr_result_type res;
  } aocr_state_type;

  aocr_state_type st_r;
  aocr_state_type st_nxt;
  aocr_cfg_type c;

  logic signed [24:0] ofs_sum;
  logic signed [41:0] gain_prod;
  logic signed [23:0] corr;
  logic [5:0] lanes;
  logic [5:0] edges;
  logic [5:0] pulses;
  logic signed [46:0] blk_sum;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration view

  always_comb begin
    c = '0;
    c.block_length_exponent = q[0][4:0];
    c.averaging_on = (q[0][4:0] != 5'h00) && (q[0][4:0] <= BLK_LEN_MAX);
    c.block_samples = 17'h00001 << q[0][4:0];
    c.averaging_restart = st_r.restart;
    c.offset_word = {q[3], q[2], q[1]};
    c.gain_word = {q[5], q[4]};
    c.output_lane_select = aocr_lane_type'(q[6][7:6]);
    c.clocking_scheme_select = aocr_clk_type'(q[6][5:4]);
    // Double rate is honoured only where the clock comes back with the data
    c.double_rate_select = q[6][3] && (q[6][5:4] == CLK_ECHO || q[6][5:4] == CLK_DEVICE);
    c.output_word_format = aocr_fmt_type'(q[6][2:0]);
    // Sixteen data bits plus eight common-mode bits also fill a 24-bit word
    c.word_bits = (c.output_word_format inside {FMT_D24, FMT_D16_CM8}) ? WORD_24 : WORD_32;
    c.pulse_count_limit = pulses;
    c.oscillator_divider = q[7][1:0];
    c.strong_drive_select = q[8][0];
    c.fixed_test_word = {q[12], q[11], q[10], q[9]};
  end

  // Clock pulses per frame less one: word bits spread over lanes, halved when both edges carry data
  always_comb begin
    case (c.output_lane_select)
      LANES_2: lanes = 6'd2;
      LANES_4: lanes = 6'd4;
      default: lanes = 6'd1;
    endcase
    edges = c.word_bits / lanes;
    if (c.double_rate_select) begin
      edges = edges >> 1;
    end
    pulses = edges - 6'd1;
  end

  always_comb begin
    case (c.oscillator_divider)
      2'b01: oscillator_divider_factor = 3'd2;
      2'b10: oscillator_divider_factor = 3'd4;
      default: oscillator_divider_factor = 3'd1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Correction: offset then gain over 0x8000

  always_comb begin
    ofs_sum = 25'(sample_diff) + 25'(c.offset_word);
    gain_prod = 42'(ofs_sum) * $signed({1'b0, c.gain_word});
    gain_prod = gain_prod >>> GAIN_SHIFT;
    if (gain_prod > 42'sh7FFFFF) begin
      corr = 24'sh7FFFFF;
    end else if (gain_prod < -42'sh800000) begin
      corr = -24'sh800000;
    end else begin
      corr = gain_prod[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Averaging, framing and read data

  always_comb begin
    blk_sum = st_r.acc + 47'(corr);
    st_nxt = st_r;
    st_nxt.fvalid = 1'b0;
    st_nxt.restart = restart_wr;
    if (st_r.restart) begin
      st_nxt.count = '0;
      st_nxt.acc = '0;
      st_nxt.ovr = 1'b0;
      st_nxt.sync_pend = 1'b1;
    end else if (sample_valid) begin
      st_nxt.res.diff = corr;
      st_nxt.res.common_mode = sample_cm;
      if (c.averaging_on) begin
        st_nxt.acc = st_r.acc + 47'(corr);
        st_nxt.ovr = st_r.ovr || (corr == 24'sh7FFFFF) || (corr == -24'sh800000);
        st_nxt.count = st_r.count + 17'd1;
        // Count ends at or past the length, so shortening the block mid-way cannot hang it
        if (st_r.count + 17'd1 >= c.block_samples) begin
          // Six fraction bits kept: short blocks shift left, long ones right
          if (c.block_length_exponent >= 5'd6) begin
            st_nxt.res.avg_diff = 30'(blk_sum >>> (c.block_length_exponent - 5'd6));
          end else begin
            st_nxt.res.avg_diff = 30'(blk_sum <<< (5'd6 - c.block_length_exponent));
          end
          st_nxt.res.overrange = st_nxt.ovr;
          st_nxt.res.block_sync = st_r.sync_pend;
          st_nxt.count = '0;
          st_nxt.acc = '0;
          st_nxt.ovr = 1'b0;
          st_nxt.sync_pend = 1'b0;
          st_nxt.fvalid = 1'b1;
        end
      end else begin
        st_nxt.res.avg_diff = {corr, 6'h00};
        st_nxt.res.overrange = (corr == 24'sh7FFFFF) || (corr == -24'sh800000);
        st_nxt.res.block_sync = 1'b1;
        st_nxt.fvalid = 1'b1;
      end
      if (st_nxt.fvalid) begin
        case (c.output_word_format)
          FMT_D24: st_nxt.frame = {8'h00, corr};
          FMT_D16_CM8: st_nxt.frame = {8'h00, corr[23:8], sample_cm};
          FMT_D24_CM8: st_nxt.frame = {corr, sample_cm};
          FMT_AVG30: st_nxt.frame = {st_nxt.res.avg_diff, st_nxt.res.overrange,
                                     st_nxt.res.block_sync};
          FMT_TEST: st_nxt.frame = c.fixed_test_word;
          default: st_nxt.frame = {8'h00, corr};
        endcase
      end
    end
    st_nxt.rdata = '0;
    if (psel && !penable && !pwrite) begin
      for (int i = 0; i < NREG; i++) begin
        if (hit[i]) begin
          st_nxt.rdata = {24'h000000, q[i]};
        end
      end
      if (hit[7]) begin
        st_nxt.rdata = {24'h000000, pulses, q[7][1:0]};
      end
    end else if (access) begin
      st_nxt.rdata = st_r.rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign cfg = c;
  assign result = st_r.res;
  assign frame_word = st_r.frame;
  assign frame_valid = st_r.fvalid;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence restart_write_s;
    restart_wr;
  endsequence

  restart_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    restart_write_s |=> st_r.restart ##1 (!st_r.restart || $past(restart_wr)))
    else $error("restart did not pulse for one cycle");
  restart_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.restart |=> st_r.count == 17'd0)
    else $error("restart did not clear block count");
  block_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    c.averaging_on |-> st_r.count < c.block_samples)
    else $error("block count passed block length");
  offset_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    c.offset_word == {q[3], q[2], q[1]})
    else $error("offset bytes misassembled");
  unity_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (c.gain_word == GAIN_UNITY && c.offset_word == 24'sh0) |-> corr == sample_diff)
    else $error("unity gain altered the sample");
  ddr_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    c.double_rate_select |-> c.clocking_scheme_select inside {CLK_ECHO, CLK_DEVICE})
    else $error("double rate with host clocking");
  test_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_valid && $past(c.output_word_format) == FMT_TEST) |->
      frame_word == $past(c.fixed_test_word))
    else $error("test frame does not carry test word");
  pulse_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (c.output_lane_select == LANES_1 && !c.double_rate_select) |->
      32'(pulses) + 32'd1 == 32'(c.word_bits))
    else $error("pulse limit wrong for one lane");
  divider_a: assert property (@(posedge pclk) disable iff (!presetn)
    c.oscillator_divider == 2'b10 |-> oscillator_divider_factor == 3'd4)
    else $error("divider code ten not four");

  // Last sample of a block, then the frame and a cleared count
  sequence block_end_s;
    sample_valid && c.averaging_on && !st_r.restart &&
      (st_r.count + 17'd1 >= c.block_samples);
  endsequence

  block_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    block_end_s |=> frame_valid && st_r.count == 17'd0)
    else $error("block end gave no frame");
  restart_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit[0]) |-> !prdata[AVG_RESTART_BIT])
    else $error("restart bit read back as one");
  osc_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit[7]) |-> prdata[7:2] == pulses)
    else $error("pulse limit not in read data");
  frame_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    frame_valid |-> $past(sample_valid))
    else $error("frame without a sample");
  avg_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_valid && $past(c.output_word_format) == FMT_AVG30) |->
      frame_word == {st_r.res.avg_diff, st_r.res.overrange, st_r.res.block_sync})
    else $error("average frame layout wrong");
  lane_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    c.output_lane_select == LANES_4 |-> lanes == 6'd4)
    else $error("four lane code not four lanes");
  div_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    c.oscillator_divider == 2'b01 |-> oscillator_divider_factor == 3'd2)
    else $error("divider code one not two");
  drive_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit[8] && pstrb[0]) |=> c.strong_drive_select == $past(pwdata[0]))
    else $error("drive bit not taken");
  test_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit[9] && pstrb[0]) |=> c.fixed_test_word[7:0] == $past(pwdata[7:0]))
    else $error("test word low byte misplaced");
  clk_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit[6] && pstrb[0]) |=> c.clocking_scheme_select == $past(pwdata[5:4]))
    else $error("clock field not taken");
  strobe_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit[8] && !pstrb[0]) |=> $stable(q[8]))
    else $error("write without byte strobe landed");
endmodule

// ---- test/adc_output_path_config_regs_tb.sv ----
// Self-checking bench for the output path configuration bank, driven over APB
`timescale 1ns/100ps
module adc_output_path_config_regs_tb;
  import aocr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_valid = 1'b0;
  logic signed [23:0] sample_diff = '0;
  logic [7:0] sample_cm = '0;
  aocr_cfg_type cfg;
  aocr_result_type result;
  logic [31:0] frame_word;
  logic frame_valid;
  logic [2:0] oscillator_divider_factor;
  int err_count = 0;
  int total_checks = 0;
  int restart_cnt = 0;
  logic [7:0] ridx [12] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h1C, 8'h1D, 8'h20, 8'h22,
    8'h23, 8'h24, 8'h25, 8'h26};
  logic [7:0] rrst [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00,
    8'h0F, 8'h0F, 8'h5A, 8'h5A};
  logic [7:0] fmts [4] = '{8'h01, 8'h02, 8'h04, 8'h00};
  logic [31:0] fexp [4] = '{32'h001234AB, 32'h123456AB, 32'h44332211, 32'h00123456};
  logic [7:0] modes [6] = '{8'h00, 8'h40, 8'h98, 8'h28, 8'h08, 8'h60};

  aocr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_diff(sample_diff), .sample_cm(sample_cm), .cfg(cfg), .result(result),
    .frame_word(frame_word), .frame_valid(frame_valid), .oscillator_divider_factor(oscillator_divider_factor));

  always #10 pclk = ~pclk;

  // Restart is a short pulse, so it is counted rather than caught by a read
  always @(posedge pclk) begin
    if (cfg.averaging_restart === 1'b1) begin
      restart_cnt <= restart_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // Request held from setup until pready is seen high; idle cycle after each
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    input logic [3:0] st, output logic [7:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      end_sim();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    bus(1'b1, idx, d, 4'hF, r, e);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    logic e;
    bus(1'b0, idx, 8'h00, 4'h0, v, e);
  endtask

  task automatic smp(input logic [23:0] d, input logic [7:0] c, output logic got,
    output logic [31:0] w);
    int k;
    sample_valid <= 1'b1;
    sample_diff <= d;
    sample_cm <= c;
    @(posedge pclk);
    sample_valid <= 1'b0;
    got = 1'b0;
    w = '0;
    for (k = 0; k < 4; k++) begin
      @(posedge pclk);
      if (frame_valid === 1'b1 && !got) begin
        got = 1'b1;
        w = frame_word;
      end
    end
  endtask

  // Gain and offset are exercised apart, so their order in the path does not matter
  task automatic gcase(input logic [15:0] g, input logic [23:0] d, input logic [23:0] e);
    logic got;
    logic [31:0] w;
    wr(8'h1C, g[7:0]);
    wr(8'h1D, g[15:8]);
    smp(d, 8'h00, got, w);
    chk(32'(got), 32'h1);
    chk(w, {8'h00, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic e;
    logic g;
    logic [31:0] w;
    int i;
    int lim;
    int rs;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 12; i++) begin
      rd(ridx[i], v);
      chk(32'(v), 32'(rrst[i]));
    end
    chk(32'(cfg.gain_word), 32'h8000);
    chk(cfg.fixed_test_word, 32'h5A5A0F0F);
    bus(1'b0, 8'h19, 8'h00, 4'h0, v, e);
    chk(32'({e, v}), 32'h100);
    gcase(16'h4000, 24'h000200, 24'h000100);
    gcase(16'h4000, 24'hFFFE00, 24'hFFFF00);
    gcase(16'hFFFF, 24'h010000, 24'h01FFFE);
    gcase(16'h8000, 24'h000000, 24'h000000);
    wr(8'h16, 8'h56);
    wr(8'h17, 8'h34);
    wr(8'h18, 8'hF2);
    chk({8'h00, cfg.offset_word}, 32'h00F23456);
    smp(24'h100000, 8'h00, g, w);
    chk(w, 32'h00023456);
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h18, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(8'h23 + 8'(i), 8'h11 * 8'(i + 1));
    end
    chk(cfg.fixed_test_word, 32'h44332211);
    for (i = 0; i < 4; i++) begin
      wr(8'h20, fmts[i]);
      chk(32'(cfg.output_word_format), 32'(fmts[i]));
      chk(32'(cfg.pulse_count_limit), (fmts[i][2:1] == 2'b00) ? 32'd23 : 32'd31);
      smp(24'h123456, 8'hAB, g, w);
      chk(w, fexp[i]);
    end
    for (i = 0; i < 6; i++) begin
      wr(8'h20, modes[i]);
      lim = ((24 >> modes[i][7:6]) >> (modes[i][3] && modes[i][5:4] != 2'b00)) - 1;
      chk(32'(cfg.output_lane_select), 32'(modes[i][7:6]));
      chk(32'(cfg.clocking_scheme_select), 32'(modes[i][5:4]));
      chk(32'(cfg.double_rate_select), 32'(modes[i][3] && modes[i][5:4] != 2'b00));
      chk(32'(cfg.pulse_count_limit), 32'(lim));
      rd(8'h21, v);
      chk(32'(v[7:2]), 32'(lim));
    end
    wr(8'h20, 8'h00);
    for (i = 0; i < 3; i++) begin
      wr(8'h21, {6'h3F, 2'(i)});
      chk(32'(oscillator_divider_factor), 32'(1 << i));
      rd(8'h21, v);
      chk(32'(v), 32'((23 << 2) | i));
    end
    bus(1'b1, 8'h22, 8'h01, 4'h0, v, e);
    rd(8'h22, v);
    chk(32'(v), 32'h0);
    wr(8'h22, 8'h01);
    rd(8'h22, v);
    chk(32'(v), 32'h1);
    chk(32'(cfg.strong_drive_select), 32'h1);
    wr(8'h20, 8'h03);
    rs = restart_cnt;
    wr(8'h15, 8'h81);
    repeat (3) @(posedge pclk);
    chk(32'(restart_cnt - rs), 32'h1);
    rd(8'h15, v);
    chk(32'(v), 32'h01);
    smp(24'h000100, 8'h00, g, w);
    chk(32'(g), 32'h0);
    smp(24'h000100, 8'h00, g, w);
    chk(32'(g), 32'h1);
    chk(w, 32'h00010001);
    chk(32'(result.avg_diff), 32'h00004000);
    chk(32'({result.overrange, result.block_sync}), 32'h1);
    for (i = 0; i <= 16; i += 4) begin
      wr(8'h15, 8'(i));
      chk(32'(cfg.averaging_on), 32'(i != 0));
      if (i != 0) begin
        chk(32'(cfg.block_samples), 32'(1 << i));
      end
    end
    end_sim();
  end
endmodule
